// ==== tb/serdes_diag_drive_regs_sva.sv ====
// Concurrent checks on the ports of the lane diagnostic and drive register bank.
module serdes_diag_drive_regs_sva
	import serdes_diag_pkg::*;
#(
	parameter logic [1:0] STATION_INDEX = 2'h0
) (
	input  wire logic             i_clock,
	input  wire logic             i_reset,
	input  wire logic [11:0]      i_cfg_addr,
	input  wire logic             i_cfg_write,
	input  wire logic             i_cfg_read,
	input  wire logic [3:0]       i_cfg_byte_en,
	input  wire logic [31:0]      i_cfg_wdata,
	input  wire logic [31:0]      o_cfg_rdata,
	input  wire logic             o_cfg_rvalid,
	input  wire logic             i_load_valid,
	input  wire logic [11:0]      i_load_addr,
	input  wire logic [31:0]      i_load_data,
	input  wire logic [3:0]       i_quad_prbs,
	input  wire logic [3:0]       i_quad_self_test_finished,
	input  wire logic [15:0][4:0] o_lane_nominal_ma,
	input  wire logic [15:0][7:0] o_lane_ratio_pct,
	input  wire logic [5:0]       o_first_lane
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_reset);

	// A loader word on the same edge wins, so only a lone full write is a clean cause.
	logic wr_all;
	assign wr_all = i_cfg_write && i_cfg_byte_en == 4'hF && !i_load_valid;

	sequence s_kind_held;
		i_quad_prbs[1] [*4];
	endsequence
	sequence s_done_held;
		i_quad_self_test_finished[3] [*3];
	endsequence

	AST_READ_ANSWER: assert property (i_cfg_read |=> o_cfg_rvalid)
		else $error("read request got no valid strobe");
	AST_NOM_10MA: assert property (wr_all && i_cfg_addr == OFF_NOMINAL &&
		i_cfg_wdata[1:0] == NOM_CODE_10MA |-> ##2 o_lane_nominal_ma[0] == CURRENT_10_MA)
		else $error("lane 0 nominal current is not 10 mA");
	AST_NOM_28MA: assert property (wr_all && i_cfg_addr == OFF_NOMINAL &&
		i_cfg_wdata[1:0] == NOM_CODE_28MA |-> ##2 o_lane_nominal_ma[0] == CURRENT_28_MA)
		else $error("lane 0 nominal current is not 28 mA");
	AST_RATIO_LOW: assert property (wr_all && i_cfg_addr == OFF_LEVEL_0_7 &&
		i_cfg_wdata[3:0] == 4'h8 |-> ##2 o_lane_ratio_pct[0] == RATIO_LOW_BASE)
		else $error("lane 0 ratio is not the low base");
	AST_RATIO_HIGH: assert property (wr_all && i_cfg_addr == OFF_LEVEL_8_15 &&
		i_cfg_wdata[3:0] == 4'h7 |-> ##2 o_lane_ratio_pct[8] == 8'h87)
		else $error("lane 8 ratio is not the top step");
	AST_LOADER_WINS: assert property (i_load_valid && i_load_addr == OFF_NOMINAL &&
		i_load_data[31:30] == NOM_CODE_28MA |-> ##2 o_lane_nominal_ma[15] == CURRENT_28_MA)
		else $error("loader word did not reach lane 15");
	AST_FIRST_LANE: assert property (!$past(i_reset) |->
		o_first_lane == ((STATION_INDEX < 2'h3) ? 6'(16 * STATION_INDEX) : 6'h00))
		else $error("first lane of station is wrong");
	AST_KIND_BIT: assert property ((s_kind_held ##0 i_cfg_read &&
		i_cfg_addr == OFF_QUAD1_DIAG) |=> o_cfg_rdata[KIND_BIT])
		else $error("count kind bit not shown");
	AST_DONE_BIT: assert property ((s_done_held ##0 i_cfg_read &&
		i_cfg_addr == OFF_QUAD3_DIAG) |=> o_cfg_rdata[DONE_BIT])
		else $error("self test finished bit not shown");
endmodule

bind serdes_diag_drive_regs serdes_diag_drive_regs_sva #(.STATION_INDEX(STATION_INDEX)) i_sva (.*);

// ==== tb/serdes_diag_drive_regs_tb.sv ====
// Self-checking bench for the lane diagnostic and drive register bank.
module serdes_diag_drive_regs_tb import serdes_diag_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic [11:0] a; logic [3:0] be; logic [31:0] d; logic [31:0] e;} row_t;
	logic             i_clock = 1'b0, i_reset = 1'b1, i_cfg_write = 1'b0, i_cfg_read = 1'b0;
	logic             i_load_valid = 1'b0, o_cfg_rvalid;
	logic [11:0]      i_cfg_addr = 12'h000, i_load_addr = 12'h000;
	logic [3:0]       i_cfg_byte_en = 4'h0, i_utp_enable = 4'h0;
	logic [3:0]       i_quad_prbs = 4'h0, i_quad_self_test_finished = 4'h0;
	logic [31:0]      i_cfg_wdata = 32'h0, i_load_data = 32'h0, o_cfg_rdata, nom_v = 32'h0;
	logic [63:0]      lvl_v = 64'h0;
	logic [15:0][7:0] i_lane_expected, i_lane_actual, o_lane_ratio_pct;
	logic [15:0]      i_lane_error = 16'h0000;
	logic [15:0][4:0] o_lane_nominal_ma;
	logic [5:0]       o_first_lane;
	int               fail_count = 0, checks = 0;
	row_t             rows [8] = '{
		'{OFF_NOMINAL, 4'hF, 32'h4E4E_4E4E, 32'h4E4E_4E4E},
		'{OFF_NOMINAL, 4'hF, 32'hB1B1_B1B1, 32'hB1B1_B1B1},
		'{OFF_LEVEL_0_7, 4'hF, 32'hFEDC_BA98, 32'hFEDC_BA98},
		'{OFF_LEVEL_8_15, 4'hF, 32'h0123_4567, 32'h0123_4567},
		'{OFF_QUAD3_DIAG, 4'hF, 32'hFFFF_FFFF, 32'h0300_0000},
		'{OFF_QUAD3_DIAG, 4'h7, 32'h0000_0000, 32'h0300_0000},
		'{OFF_QUAD1_DIAG, 4'h8, 32'h0200_0000, 32'h0200_0000},
		'{12'h300, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000}};

	serdes_diag_drive_regs #(.STATION_INDEX(2'h1)) i_serdes_diag_drive_regs (.*);

	always #2.5 i_clock = ~i_clock;

	function automatic logic [4:0] nom(input logic [1:0] c);
		return (c == 2'h1) ? 5'h0A : (c == 2'h2) ? 5'h1C : 5'h14;
	endfunction
	function automatic logic [7:0] ratio(input logic [3:0] c);
		return (c[3] ? 8'h3C : 8'h64) + 8'(c[2:0]) * 8'h05;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
		@(posedge i_clock);
		i_cfg_addr <= a;
		i_cfg_byte_en <= b;
		i_cfg_wdata <= d;
		i_cfg_write <= 1'b1;
		@(posedge i_clock);
		i_cfg_write <= 1'b0;
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		@(posedge i_clock);
		i_cfg_addr <= a;
		i_cfg_read <= 1'b1;
		@(posedge i_clock);
		i_cfg_read <= 1'b0;
		#1;
		chk(32'(o_cfg_rvalid), 32'h1);
		chk(o_cfg_rdata, e);
	endtask
	// Pulses are spaced apart so each one is a single error event.
	task automatic errs(input int l, input int n);
		repeat (n) begin
			@(posedge i_clock);
			i_lane_error[l] <= 1'b1;
			@(posedge i_clock);
			i_lane_error[l] <= 1'b0;
		end
		repeat (4) @(posedge i_clock);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		#50000;
		fail_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		end_sim();
	end

	initial begin
		for (int l = 0; l < 16; l++) begin
			i_lane_expected[l] <= 8'(8'h10 + l);
			i_lane_actual[l] <= 8'(8'hA0 + l);
		end
		repeat (5) @(posedge i_clock);
		i_reset <= 1'b0;
		#1;
		chk(32'(o_lane_nominal_ma[3]), 32'h14);
		chk(32'(o_lane_ratio_pct[12]), 32'h64);
		for (int a = 0; a < 7; a++)
			rd_chk(12'(OFF_QUAD0_DIAG + 4 * a), 32'h0);
		$display("reset test done");
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].be, rows[i].d);
			rd_chk(rows[i].a, rows[i].e);
			if (rows[i].a == OFF_NOMINAL)
				nom_v = rows[i].d;
			if (rows[i].a == OFF_LEVEL_0_7)
				lvl_v[31:0] = rows[i].d;
			if (rows[i].a == OFF_LEVEL_8_15)
				lvl_v[63:32] = rows[i].d;
			repeat (2) @(posedge i_clock);
			#1;
			for (int l = 0; l < 16; l++) begin
				chk(32'(o_lane_nominal_ma[l]), 32'(nom(nom_v[2*l +: 2])));
				chk(32'(o_lane_ratio_pct[l]), 32'(ratio(lvl_v[4*l +: 4])));
			end
		end
		$display("table test done");
		@(posedge i_clock);
		i_utp_enable <= 4'hF;
		for (int q = 0; q < 4; q++)
			for (int s = 0; s < 4; s++) begin
				wr(12'(OFF_QUAD0_DIAG + 4 * q), 4'h8, 32'(s) << 24);
				repeat (2) @(posedge i_clock);
				rd_chk(12'(OFF_QUAD0_DIAG + 4 * q), {6'h00, 2'(s), 8'h00,
					8'(8'hA0 + 4 * q + s), 8'(8'h10 + 4 * q + s)});
			end
		@(posedge i_clock);
		i_utp_enable <= 4'hA;
		repeat (3) @(posedge i_clock);
		rd_chk(OFF_QUAD0_DIAG, 32'h0300_0000);
		rd_chk(OFF_QUAD2_DIAG, 32'h0300_0000);
		$display("select test done");
		errs(7, 3);
		errs(6, 2);
		rd_chk(OFF_QUAD1_DIAG, 32'h0303_A717);
		errs(7, 260);
		rd_chk(OFF_QUAD1_DIAG, 32'h03FF_A717);
		wr(OFF_QUAD1_DIAG, 4'h8, 32'h0200_0000);
		repeat (2) @(posedge i_clock);
		rd_chk(OFF_QUAD1_DIAG, 32'h0202_A616);
		@(posedge i_clock);
		i_quad_prbs <= 4'h2;
		repeat (4) @(posedge i_clock);
		rd_chk(OFF_QUAD1_DIAG, 32'h4200_A616);
		@(posedge i_clock);
		i_quad_self_test_finished <= 4'h8;
		repeat (3) @(posedge i_clock);
		rd_chk(OFF_QUAD3_DIAG, 32'h8300_AF1F);
		$display("count test done");
		@(posedge i_clock);
		i_load_valid <= 1'b1;
		i_load_addr <= OFF_NOMINAL;
		i_load_data <= 32'h8000_0000;
		i_cfg_write <= 1'b1;
		i_cfg_addr <= OFF_NOMINAL;
		i_cfg_byte_en <= 4'hF;
		i_cfg_wdata <= 32'h0;
		@(posedge i_clock);
		i_load_valid <= 1'b0;
		i_cfg_write <= 1'b0;
		rd_chk(OFF_NOMINAL, 32'h8000_0000);
		repeat (2) @(posedge i_clock);
		#1;
		chk(32'(o_lane_nominal_ma[15]), 32'h1C);
		chk(32'(o_first_lane), 32'h10);
		$display("loader test done");
		end_sim();
	end
endmodule

// ==== verilog/lane_drive_decode.sv ====
// Decodes one lane's drive codes into nominal current and scaling ratio.
module lane_drive_decode
	import serdes_diag_pkg::*;
(
	input  wire logic       i_clock,
	input  wire logic       i_reset,
	input  wire logic [1:0] i_nominal_code,
	input  wire logic [3:0] i_level_code,
	output logic      [4:0] o_nominal_ma,
	output logic      [7:0] o_ratio_pct
);

	logic [7:0] step_reg_next;

	always_comb begin
		step_reg_next = 8'(RATIO_STEP * {5'h00, i_level_code[2:0]});
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_nominal_ma <= CURRENT_20_MA;
		end else begin
			unique case (i_nominal_code)
				NOM_CODE_10MA: o_nominal_ma <= CURRENT_10_MA;
				NOM_CODE_28MA: o_nominal_ma <= CURRENT_28_MA;
				default:       o_nominal_ma <= CURRENT_20_MA;
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_ratio_pct <= RATIO_HIGH_BASE;
		end else if (i_level_code[3]) begin
			o_ratio_pct <= 8'(RATIO_LOW_BASE + step_reg_next);
		end else begin
			o_ratio_pct <= 8'(RATIO_HIGH_BASE + step_reg_next);
		end
	end

endmodule

// ==== verilog/quad_diag_if.sv ====
// Link between the register bank and one quad's diagnostic status logic.
interface quad_diag_if;
	logic [1:0]  select;
	logic        utp_enable;
	logic [31:0] status;

	modport regs (output select, output utp_enable, input status);
	modport diag (input select, input utp_enable, output status);
endinterface

// ==== verilog/quad_diag_status.sv ====
// Per-quad error counters and the selected lane's diagnostic status word.
module quad_diag_status
	import serdes_diag_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_reset,
	input  wire logic [31:0] i_expected,
	input  wire logic [31:0] i_actual,
	input  wire logic [3:0]  i_error,
	input  wire logic        i_prbs_mode,
	input  wire logic        i_self_test_finished,
	quad_diag_if.diag        diag
);

	logic [3:0][7:0] count_reg;
	logic            kind_reg;
	logic [1:0]      sel;

	assign sel = diag.select;

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			kind_reg <= 1'b0;
		end else begin
			kind_reg <= i_prbs_mode;
		end
	end

	// A change of count kind restarts the counts so the two kinds never mix.
	// An error seen in that same cycle is still counted.
	for (genvar l = 0; l < LANES_PER_QUAD; l++) begin : g_lane
		always_ff @(posedge i_clock) begin
			if (i_reset) begin
				count_reg[l] <= COUNT_RESET;
			end else if (kind_reg != i_prbs_mode) begin
				count_reg[l] <= {7'h00, i_error[l]};
			end else if (i_error[l] && count_reg[l] != COUNT_MAX) begin
				count_reg[l] <= 8'(count_reg[l] + 8'h01);
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			diag.status <= 32'h0000_0000;
		end else begin
			diag.status <= 32'h0000_0000;
			diag.status[DONE_BIT] <= i_self_test_finished;
			diag.status[KIND_BIT] <= kind_reg;
			diag.status[COUNT_LSB +: 8] <= count_reg[sel];
			if (diag.utp_enable) begin
				diag.status[EXPECTED_LSB +: 8] <= i_expected[8*sel +: 8];
				diag.status[ACTUAL_LSB +: 8]   <= i_actual[8*sel +: 8];
			end
		end
	end

endmodule

// ==== verilog/serdes_diag_drive_regs.sv ====
// Diagnostic and drive current register bank for one station's sixteen lanes.
//
// How it works
// - Diagnostic count and pattern bytes follow that register's selector.
// - Selector codes 0..3 pick quad lanes; reset 0.
// - Selected lane error count in bits 23:16.
// - Bit 30 shows pattern or pseudo-random count.
// - Expected and received pattern bytes when enabled.
// - Quads 1..3 data gated by enables 29..31.
// - Each quad register serves four consecutive lanes.
// - Three stations cover lanes 0..15, 16..31, 32..47.
// - Nominal codes give 20, 10, 28, 20 mA.
// - Sixteen sticky 2-bit nominal fields, loadable, reset 0.
// - Level codes scale current 1.00..1.35, 0.60..0.95.
// - Lanes 0..7 level nibbles, sticky, reset 0.
// - Lanes 8..15 level nibbles, lowest lane lowest.
// - Quad 0 data gated by enable 28.
module serdes_diag_drive_regs
	import serdes_diag_pkg::*;
#(
	parameter logic [1:0] STATION_INDEX = 2'h0
) (
	input  wire logic                 i_clock,
	input  wire logic                 i_reset,
	input  wire logic [11:0]          i_cfg_addr,
	input  wire logic                 i_cfg_write,
	input  wire logic                 i_cfg_read,
	input  wire logic [3:0]           i_cfg_byte_en,
	input  wire logic [31:0]          i_cfg_wdata,
	output logic      [31:0]          o_cfg_rdata,
	output logic                      o_cfg_rvalid,
	input  wire logic                 i_load_valid,
	input  wire logic [11:0]          i_load_addr,
	input  wire logic [31:0]          i_load_data,
	input  wire logic [3:0]           i_utp_enable,
	input  wire logic [3:0]           i_quad_prbs,
	input  wire logic [3:0]           i_quad_self_test_finished,
	input  wire logic [15:0][7:0]     i_lane_expected,
	input  wire logic [15:0][7:0]     i_lane_actual,
	input  wire logic [15:0]          i_lane_error,
	output logic      [15:0][4:0]     o_lane_nominal_ma,
	output logic      [15:0][7:0]     o_lane_ratio_pct,
	output logic      [5:0]           o_first_lane
);

	logic [31:0]      nominal_reg;
	logic [31:0]      level_lo_reg;
	logic [31:0]      level_hi_reg;
	logic [3:0][1:0]  select_reg;
	logic [3:0][31:0] quad_word;
	logic [31:0]      read_next;

	// Configuration writes honour byte enables; loader writes are whole words.
	function automatic logic [31:0] merge_bytes(
		input logic [31:0] old_value,
		input logic [31:0] new_value,
		input logic [3:0]  byte_en
	);
		logic [31:0] result;
		result = old_value;
		for (int b = 0; b < 4; b++) begin
			if (byte_en[b]) begin
				result[8*b +: 8] = new_value[8*b +: 8];
			end
		end
		return result;
	endfunction

	// The first lane of this station; only three stations exist.
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_first_lane <= 6'h00;
		end else if (STATION_INDEX < 2'(STATIONS)) begin
			o_first_lane <= 6'(LANES * int'(STATION_INDEX));
		end else begin
			o_first_lane <= 6'h00;
		end
	end

	// Drive settings are only cleared by the device reset, never by link events.
	// A loader word in the same cycle as a software write takes precedence.
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			nominal_reg <= DRIVE_RESET;
		end else if (i_load_valid && i_load_addr == OFF_NOMINAL) begin
			nominal_reg <= i_load_data;
		end else if (i_cfg_write && i_cfg_addr == OFF_NOMINAL) begin
			nominal_reg <= merge_bytes(nominal_reg, i_cfg_wdata, i_cfg_byte_en);
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			level_lo_reg <= DRIVE_RESET;
		end else if (i_load_valid && i_load_addr == OFF_LEVEL_0_7) begin
			level_lo_reg <= i_load_data;
		end else if (i_cfg_write && i_cfg_addr == OFF_LEVEL_0_7) begin
			level_lo_reg <= merge_bytes(level_lo_reg, i_cfg_wdata, i_cfg_byte_en);
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			level_hi_reg <= DRIVE_RESET;
		end else if (i_load_valid && i_load_addr == OFF_LEVEL_8_15) begin
			level_hi_reg <= i_load_data;
		end else if (i_cfg_write && i_cfg_addr == OFF_LEVEL_8_15) begin
			level_hi_reg <= merge_bytes(level_hi_reg, i_cfg_wdata, i_cfg_byte_en);
		end
	end

	quad_diag_if qif [QUADS] ();

	for (genvar q = 0; q < QUADS; q++) begin : g_quad
		localparam logic [11:0] QUAD_OFFSET = 12'(OFF_QUAD0_DIAG + QUAD_STRIDE * 12'(q));

		always_ff @(posedge i_clock) begin
			if (i_reset) begin
				select_reg[q] <= SELECT_RESET;
			end else if (i_load_valid && i_load_addr == QUAD_OFFSET) begin
				select_reg[q] <= i_load_data[SELECT_LSB +: 2];
			end else if (i_cfg_write && i_cfg_addr == QUAD_OFFSET
					&& i_cfg_byte_en[SELECT_BYTE]) begin
				select_reg[q] <= i_cfg_wdata[SELECT_LSB +: 2];
			end
		end

		assign qif[q].select     = select_reg[q];
		assign qif[q].utp_enable = i_utp_enable[q];
		assign quad_word[q]      = qif[q].status;

		// Quad q serves lanes 4q..4q+3 of the station.
		quad_diag_status u_quad (
			.i_clock     (i_clock),
			.i_reset     (i_reset),
			.i_expected  (i_lane_expected[LANES_PER_QUAD*q +: LANES_PER_QUAD]),
			.i_actual    (i_lane_actual[LANES_PER_QUAD*q +: LANES_PER_QUAD]),
			.i_error     (i_lane_error[LANES_PER_QUAD*q +: LANES_PER_QUAD]),
			.i_prbs_mode (i_quad_prbs[q]),
			.i_self_test_finished (i_quad_self_test_finished[q]),
			.diag        (qif[q])
		);
	end

	for (genvar l = 0; l < LANES; l++) begin : g_drive
		logic [3:0] level_code;

		if (l < 8) begin : g_lo
			assign level_code = level_lo_reg[LEVEL_WIDTH*l +: LEVEL_WIDTH];
		end else begin : g_hi
			assign level_code = level_hi_reg[LEVEL_WIDTH*(l-8) +: LEVEL_WIDTH];
		end

		lane_drive_decode u_decode (
			.i_clock        (i_clock),
			.i_reset        (i_reset),
			.i_nominal_code (nominal_reg[NOMINAL_WIDTH*l +: NOMINAL_WIDTH]),
			.i_level_code   (level_code),
			.o_nominal_ma   (o_lane_nominal_ma[l]),
			.o_ratio_pct    (o_lane_ratio_pct[l])
		);
	end

	// Reads return one cycle after the request; unmapped offsets read zero.
	always_comb begin
		read_next = READ_UNMAPPED;
		unique case (i_cfg_addr)
			OFF_QUAD0_DIAG: read_next = quad_word[0] | {6'h00, select_reg[0], 24'h000000};
			OFF_QUAD1_DIAG: read_next = quad_word[1] | {6'h00, select_reg[1], 24'h000000};
			OFF_QUAD2_DIAG: read_next = quad_word[2] | {6'h00, select_reg[2], 24'h000000};
			OFF_QUAD3_DIAG: read_next = quad_word[3] | {6'h00, select_reg[3], 24'h000000};
			OFF_NOMINAL:    read_next = nominal_reg;
			OFF_LEVEL_0_7:  read_next = level_lo_reg;
			OFF_LEVEL_8_15: read_next = level_hi_reg;
			default:        read_next = READ_UNMAPPED;
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_cfg_rdata  <= READ_UNMAPPED;
			o_cfg_rvalid <= 1'b0;
		end else begin
			o_cfg_rvalid <= i_cfg_read;
			if (i_cfg_read) begin
				o_cfg_rdata <= read_next;
			end
		end
	end

endmodule

// ==== verilog/serdes_diag_pkg.sv ====
// Shared constants for the serial lane diagnostic and drive register bank.
package serdes_diag_pkg;

	localparam int LANES          = 16;
	localparam int QUADS          = 4;
	localparam int LANES_PER_QUAD = 4;
	localparam int STATIONS       = 3;

	// Register byte offsets in configuration space.
	localparam logic [11:0] OFF_QUAD0_DIAG   = 12'h238;
	localparam logic [11:0] OFF_QUAD1_DIAG   = 12'h23C;
	localparam logic [11:0] OFF_QUAD2_DIAG   = 12'h240;
	localparam logic [11:0] OFF_QUAD3_DIAG   = 12'h244;
	localparam logic [11:0] OFF_NOMINAL      = 12'h248;
	localparam logic [11:0] OFF_LEVEL_0_7    = 12'h24C;
	localparam logic [11:0] OFF_LEVEL_8_15   = 12'h250;
	localparam logic [11:0] QUAD_STRIDE      = 12'h004;

	// Diagnostic register field positions.
	localparam int EXPECTED_LSB = 0;
	localparam int ACTUAL_LSB   = 8;
	localparam int COUNT_LSB    = 16;
	localparam int SELECT_LSB   = 24;
	localparam int SELECT_BYTE  = 3;
	localparam int KIND_BIT     = 30;
	localparam int DONE_BIT     = 31;

	// Reset values and the saturation limit of the error counts.
	localparam logic [1:0]  SELECT_RESET  = 2'h0;
	localparam logic [7:0]  COUNT_RESET   = 8'h00;
	localparam logic [7:0]  COUNT_MAX     = 8'hFF;
	localparam logic [7:0]  PATTERN_RESET = 8'h00;
	localparam logic [31:0] DRIVE_RESET   = 32'h0000_0000;
	localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

	// Drive code field widths, nominal drive current codes and their currents in mA.
	localparam int NOMINAL_WIDTH = 2;
	localparam int LEVEL_WIDTH   = 4;
	localparam logic [1:0] NOM_CODE_10MA = 2'h1;
	localparam logic [1:0] NOM_CODE_28MA = 2'h2;
	localparam logic [4:0] CURRENT_20_MA = 5'h14;
	localparam logic [4:0] CURRENT_10_MA = 5'h0A;
	localparam logic [4:0] CURRENT_28_MA = 5'h1C;

	// Drive level ratios, in hundredths of the nominal current.
	localparam logic [7:0] RATIO_HIGH_BASE = 8'h64;
	localparam logic [7:0] RATIO_LOW_BASE  = 8'h3C;
	localparam logic [7:0] RATIO_STEP      = 8'h05;

endpackage
